/* src/ipc_ctrl.sv */
// Behaviour
// R1 - 3-bit level field, 7 highest, 1 lowest
// R2 - Level zero disables the source
// R3 - Unimplemented bits read zero, ignore writes
// R4 - Reset loads level four everywhere
// R5 - Nest disable bit 15 blocks preemption
// R6 - Software sets level, clears flag, enables
// R7 - Pending flag left set re-enters handler
// R8 - Return restores pc, status low, level
// R9 - Trap flag must be cleared by handler
// R10 - CPU level 7 blocks all user sources
// R11 - Traps 8 to 15 never masked; the code has four traps, at levels 8 to 11
// R12 - Timed disable blocks levels 1-6 a while
// R13 - Level 7 passes during timed disable
// R14 - I2C2 master 10:8, slave 6:4
// R15 - Calendar level at bits 10:8
// R16 - Checksum error level at 14:12
// R17 - Serial2 error 10:8, serial1 6:4
// R18 - Low voltage level at 2:0
// R19 - Highest level wins, ties by index
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`default_nettype none
module ipc_ctrl
    import ipc_pkg::*;
#(
    parameter int STACK_DEPTH = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic [NUM_TRAP-1:0] trap_event,
    input wire logic accept,
    input wire logic [15:0] accept_pc,
    input wire logic return_from_handler_instr,
    input wire logic timed_disable_instr,
    input wire logic [13:0] timed_disable_count,
    output ipc_req_s request,
    output logic [15:0] restore_pc,
    output logic [7:0] status_low_byte,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] i2c2_event_priority;
    logic [15:0] rtc_event_priority;
    logic [15:0] crc_uart_error_priority;
    logic [15:0] low_voltage_priority;
    logic [15:0] intr_control_one;
    logic [NUM_SRC-1:0] pending_flag_regs;
    logic [NUM_SRC-1:0] source_enable_regs;
    logic [13:0] mute_left;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic in_handler;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [15:0] w_data;
    logic wr_fire;
    logic [2:0] lvl [NUM_SRC];
    ipc_req_s next_request;
    ipc_frame_s top_frame;
    logic stack_empty;
    logic take;
    logic take_trap;
    ipc_frame_s push_frame;

    function automatic logic [15:0] merge(input logic [15:0] old_v,
        input logic [15:0] new_v, input logic [15:0] wmask);
        merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 16'h0000;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                // Upper half of the word is not backed by storage
                w_data <= s_axi_wdata[15:0];
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'h0;

    ////////////////////////////////////////////////////////////////////
    // Priority registers; writes confined to implemented fields
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // R4 reset level four
            i2c2_event_priority <= 16'h0440;
            rtc_event_priority <= 16'h0400;
            crc_uart_error_priority <= 16'h4440;
            low_voltage_priority <= 16'h0004;
        end
        else if (wr_fire)
        begin
            // R3 masked field writes
            unique case (aw_addr)
                ADDR_I2C2_PRIO: i2c2_event_priority <=
                    merge(i2c2_event_priority, w_data, MASK_I2C2);
                ADDR_RTC_PRIO: rtc_event_priority <=
                    merge(rtc_event_priority, w_data, MASK_RTC);
                ADDR_CRC_UART_PRIO: crc_uart_error_priority <=
                    merge(crc_uart_error_priority, w_data, MASK_CRC_UART);
                ADDR_LVD_PRIO: low_voltage_priority <=
                    merge(low_voltage_priority, w_data, MASK_LVD);
                default: ;
            endcase
        end
    end

    // R14 i2c2 fields
    assign lvl[0] = i2c2_event_priority[POS_I2C2_MASTER +: 3];
    assign lvl[1] = i2c2_event_priority[POS_I2C2_SLAVE +: 3];
    // R15 calendar field
    assign lvl[2] = rtc_event_priority[POS_RTC +: 3];
    // R16 checksum field
    assign lvl[3] = crc_uart_error_priority[POS_CRC +: 3];
    // R17 serial error fields
    assign lvl[4] = crc_uart_error_priority[POS_U2ERR +: 3];
    assign lvl[5] = crc_uart_error_priority[POS_U1ERR +: 3];
    // R18 low voltage field
    assign lvl[6] = low_voltage_priority[POS_LVD +: 3];

    ////////////////////////////////////////////////////////////////////
    // Control register: nest disable and trap flags, set beats clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            intr_control_one <= 16'h0000;
        end
        else
        begin
            if (wr_fire && aw_addr == ADDR_INTR_CTRL_ONE)
            begin
                // R9 handler clears its trap flag
                intr_control_one <= merge(intr_control_one, w_data,
                    MASK_CTRL_ONE);
            end
            intr_control_one[POS_TRAP_FLAGS +: NUM_TRAP] <=
                (wr_fire && aw_addr == ADDR_INTR_CTRL_ONE ?
                w_data[POS_TRAP_FLAGS +: NUM_TRAP] :
                intr_control_one[POS_TRAP_FLAGS +: NUM_TRAP]) | trap_event;
        end
    end

    // Pending flags and enables; a new event beats a clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pending_flag_regs <= '0;
            source_enable_regs <= '0;
        end
        else
        begin
            // R6 software writes flags and enables
            if (wr_fire && aw_addr == ADDR_SRC_ENABLE)
            begin
                source_enable_regs <= w_data[NUM_SRC-1:0];
            end
            // R7 flag stays until software clears it
            pending_flag_regs <= (wr_fire && aw_addr == ADDR_SRC_PEND ?
                w_data[NUM_SRC-1:0] : pending_flag_regs) | src_event;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Timed disable down-counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mute_left <= '0;
        end
        else if (timed_disable_instr)
        begin
            mute_left <= timed_disable_count;
        end
        else if (wr_fire && aw_addr == ADDR_MUTE_COUNT)
        begin
            mute_left <= w_data[13:0];
        end
        else if (mute_left != 0)
        begin
            mute_left <= mute_left - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Selection of the request to present
    always_comb
    begin
        logic [3:0] cur;
        cur = {1'b0, status_low_byte[7:5]};
        next_request = '0;
        // R11 traps ignore every mask
        for (int t = NUM_TRAP - 1; t >= 0; t--)
        begin
            if (intr_control_one[POS_TRAP_FLAGS + t] && !next_request.valid)
            begin
                next_request.valid = 1'b1;
                next_request.is_trap = 1'b1;
                next_request.level = 4'(8 + t);
                next_request.id = 3'(t);
            end
        end
        if (!next_request.valid)
        begin
            // R19 highest level, lowest index on ties
            for (int s = 0; s < NUM_SRC; s++)
            begin
                // R2 level zero never requests
                // R10 level must exceed cpu level
                // R12 R13 timed disable spares level 7
                // R5 nest disable holds off preemption
                if (pending_flag_regs[s] && source_enable_regs[s]
                    && lvl[s] != LEVEL_OFF
                    && {1'b0, lvl[s]} > cur
                    && !(mute_left != 0 && lvl[s] != LEVEL_TOP)
                    && !(intr_control_one[POS_NEST_DISABLE] && in_handler)
                    && (!next_request.valid
                    || {1'b0, lvl[s]} > next_request.level))
                begin
                    // R1 field value is the level
                    next_request.valid = 1'b1;
                    next_request.level = {1'b0, lvl[s]};
                    next_request.id = 3'(s);
                end
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            request <= '0;
        end
        else
        begin
            request <= next_request;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Entry stacks state; return unstacks it
    assign take = accept && request.valid;
    assign take_trap = take && request.is_trap;
    assign push_frame = '{pc: accept_pc, status_low_byte: status_low_byte};

    ipc_stack_mem #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(take),
        .push_data(push_frame),
        .pop(return_from_handler_instr && !stack_empty),
        .top_data(top_frame),
        .empty(stack_empty)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_low_byte <= 8'h00;
            restore_pc <= 16'h0000;
        end
        else if (take)
        begin
            // Trap levels above 7 saturate the 3-bit cpu level
            status_low_byte[7:5] <= take_trap ? LEVEL_TOP
                : request.level[2:0];
        end
        else if (return_from_handler_instr && !stack_empty)
        begin
            // R8 restore pc, status low and level
            restore_pc <= top_frame.pc;
            status_low_byte <= top_frame.status_low_byte;
        end
        else if (wr_fire && aw_addr == ADDR_CPU_STATUS)
        begin
            // R10 raising level by software write
            status_low_byte <= w_data[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_handler <= 1'b0;
        end
        else if (take)
        begin
            in_handler <= 1'b1;
        end
        else if (return_from_handler_instr)
        begin
            // A return clears the flag unless an entry is taken in the same cycle, even with frames left on the stack
            in_handler <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky event bits, write one to clear, set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_status <= '0;
            irq_mask <= '0;
        end
        else
        begin
            if (wr_fire && aw_addr == ADDR_IRQ_MASK)
            begin
                irq_mask <= w_data[2:0];
            end
            irq_status <= (irq_status & ~((wr_fire
                && aw_addr == ADDR_IRQ_STATUS) ? w_data[2:0] : 3'h0))
                | {return_from_handler_instr, |trap_event, take};
        end
    end
    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////
    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr[7:0])
                ADDR_I2C2_PRIO: s_axi_rdata <= {16'h0000,
                    i2c2_event_priority};
                ADDR_RTC_PRIO: s_axi_rdata <= {16'h0000, rtc_event_priority};
                ADDR_CRC_UART_PRIO: s_axi_rdata <= {16'h0000,
                    crc_uart_error_priority};
                ADDR_LVD_PRIO: s_axi_rdata <= {16'h0000,
                    low_voltage_priority};
                ADDR_INTR_CTRL_ONE: s_axi_rdata <= {16'h0000,
                    intr_control_one};
                ADDR_SRC_PEND: s_axi_rdata <= {25'h0, pending_flag_regs};
                ADDR_SRC_ENABLE: s_axi_rdata <= {25'h0, source_enable_regs};
                ADDR_CPU_STATUS: s_axi_rdata <= {24'h0, status_low_byte};
                ADDR_MUTE_COUNT: s_axi_rdata <= {18'h0, mute_left};
                ADDR_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status};
                ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                ADDR_ACTIVE: s_axi_rdata <= {23'h0, request};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // R2 disabled source never presented
    property p_off_no_req;
        @(posedge aclk) disable iff (!aresetn)
        request.valid && !request.is_trap |-> request.level != 4'h0;
    endproperty
    a_off_no_req: assert property (p_off_no_req) // R2
        else $error("request at level zero");

    property p_trap_wins;
        @(posedge aclk) disable iff (!aresetn)
        |intr_control_one[POS_TRAP_FLAGS +: NUM_TRAP] |=> request.is_trap;
    endproperty
    a_trap_wins: assert property (p_trap_wins) // R11
        else $error("pending trap not presented");

    property p_cpu_mask;
        @(posedge aclk) disable iff (!aresetn)
        request.valid && !request.is_trap |->
            request.level > {1'b0, $past(status_low_byte[7:5])};
    endproperty
    a_cpu_mask: assert property (p_cpu_mask) // R10
        else $error("request not above cpu level");

    property p_mute;
        @(posedge aclk) disable iff (!aresetn)
        $past(mute_left) != 0 && request.valid && !request.is_trap
            |-> request.level == 4'h7;
    endproperty
    a_mute: assert property (p_mute) // R12
        else $error("low level passed timed disable");

    property p_reset_level;
        @(posedge aclk)
        !aresetn |=> lvl[6] == LEVEL_RESET && lvl[3] == LEVEL_RESET;
    endproperty
    a_reset_level: assert property (p_reset_level) // R4
        else $error("reset level not four");

    property p_unimpl;
        @(posedge aclk) disable iff (!aresetn)
        (i2c2_event_priority & ~MASK_I2C2) == 16'h0
            && (low_voltage_priority & ~MASK_LVD) == 16'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) // R3
        else $error("unimplemented bit set");

    property p_nest;
        @(posedge aclk) disable iff (!aresetn)
        $past(intr_control_one[POS_NEST_DISABLE] && in_handler)
            && request.valid |-> request.is_trap;
    endproperty
    a_nest: assert property (p_nest) // R5
        else $error("preemption with nesting off");

    sequence s_ret;
        return_from_handler_instr && !stack_empty && !take;
    endsequence
    property p_return;
        @(posedge aclk) disable iff (!aresetn)
        s_ret |=> status_low_byte == $past(top_frame.status_low_byte);
    endproperty
    a_return: assert property (p_return) // R8
        else $error("status not restored on return");
endmodule : ipc_ctrl
`default_nettype wire

/* src/ipc_pkg.sv */
`default_nettype none
package ipc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_I2C2_PRIO = 8'h00;
    localparam logic [7:0] ADDR_RTC_PRIO = 8'h04;
    localparam logic [7:0] ADDR_CRC_UART_PRIO = 8'h08;
    localparam logic [7:0] ADDR_LVD_PRIO = 8'h0C;
    localparam logic [7:0] ADDR_INTR_CTRL_ONE = 8'h10;
    localparam logic [7:0] ADDR_SRC_PEND = 8'h14;
    localparam logic [7:0] ADDR_SRC_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_CPU_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_MUTE_COUNT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ADDR_ACTIVE = 8'h2C;
    // Field positions (low bit of each field)
    localparam int POS_I2C2_MASTER = 8;
    localparam int POS_I2C2_SLAVE = 4;
    localparam int POS_RTC = 8;
    localparam int POS_CRC = 12;
    localparam int POS_U2ERR = 8;
    localparam int POS_U1ERR = 4;
    localparam int POS_LVD = 0;
    localparam int POS_NEST_DISABLE = 15;
    localparam int POS_TRAP_FLAGS = 1;
    // Writable masks per register
    localparam logic [15:0] MASK_I2C2 = 16'h0770;
    localparam logic [15:0] MASK_RTC = 16'h0700;
    localparam logic [15:0] MASK_CRC_UART = 16'h7770;
    localparam logic [15:0] MASK_LVD = 16'h0007;
    localparam logic [15:0] MASK_CTRL_ONE = 16'h801E;
    // Reset level of every user source
    localparam logic [2:0] LEVEL_RESET = 3'h4;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [2:0] LEVEL_TOP = 3'h7;
    localparam logic [15:0] MUTE_LEVEL_LIMIT = 16'h0006;
    localparam int NUM_SRC = 7;
    localparam int NUM_TRAP = 4;
    // Event bits of the irq status register
    localparam int EV_ACCEPT = 0;
    localparam int EV_TRAP = 1;
    localparam int EV_RETURN = 2;
    typedef struct packed {
        logic valid;
        logic is_trap;
        logic [3:0] level;
        logic [2:0] id;
    } ipc_req_s;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] status_low_byte;
    } ipc_frame_s;
endpackage : ipc_pkg
`default_nettype wire

/* src/ipc_stack_mem.sv */
`default_nettype none
module ipc_stack_mem
    import ipc_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic push,
    input wire ipc_frame_s push_data,
    input wire logic pop,
    output ipc_frame_s top_data,
    output logic empty
);
    logic [$clog2(DEPTH):0] sp;
    ipc_frame_s mem [DEPTH];
    logic [$clog2(DEPTH):0] rd;

    always_comb
    begin
        rd = sp - 1'b1;
        if (push)
        begin
            rd = sp;
        end
        else if (pop && sp > 1)
        begin
            rd = sp - 2'd2;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem[sp[$clog2(DEPTH)-1:0]] <= push_data;
        end
    end

    // Top of stack comes out of a register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            top_data <= '0;
        end
        else if (push)
        begin
            top_data <= push_data;
        end
        else if (pop)
        begin
            top_data <= mem[rd[$clog2(DEPTH)-1:0]];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sp <= '0;
        end
        else if (push && sp < DEPTH)
        begin
            sp <= sp + 1'b1;
        end
        else if (pop && sp != 0)
        begin
            sp <= sp - 1'b1;
        end
    end

    assign empty = (sp == 0);
endmodule : ipc_stack_mem
`default_nettype wire

/* tb/ipc_core_model.sv */
`default_nettype none
module ipc_core_model
    import ipc_pkg::*;
#(
    parameter int HOLD = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire ipc_req_s request,
    output logic accept,
    output logic [15:0] accept_pc,
    output logic ret
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PC = 16'h1234;
    initial
    begin
        accept = 1'b0;
        accept_pc = 16'h0000;
        ret = 1'b0;
    end
    // Takes one request per go pulse, then returns after HOLD cycles
    always
    begin
        @(posedge aclk);
        if (aresetn && go && request.valid)
        begin
            accept <= 1'b1;
            accept_pc <= PC;
            @(posedge aclk);
            accept <= 1'b0;
            // Released bus shows the inverse, not a stale value
            accept_pc <= ~PC;
            repeat (HOLD) @(posedge aclk);
            ret <= 1'b1;
            @(posedge aclk);
            ret <= 1'b0;
        end
    end
endmodule : ipc_core_model
`default_nettype wire

/* tb/interrupt_priority_control_tb.sv */
`default_nettype none
module interrupt_priority_control_tb
    import ipc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd;
    logic awr, wr_rdy, bv, arr, rv, acc, ret, go = 0, tdi = 0, irq;
    logic [1:0] bresp, rresp;
    logic [6:0] src = 0;
    logic [3:0] trp = 0;
    logic [13:0] tdc = 0;
    logic [15:0] apc, rpc;
    logic [7:0] slb;
    ipc_req_s req;
    int num_errors = 0, checked = 0;
    logic [31:0] expq[$];
    ipc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .src_event(src), .trap_event(trp), .accept(acc),
        .accept_pc(apc), .return_from_handler_instr(ret),
        .timed_disable_instr(tdi), .timed_disable_count(tdc),
        .request(req), .restore_pc(rpc), .status_low_byte(slb), .irq(irq));
    ipc_core_model #(.HOLD(6)) i_core (.aclk(aclk), .aresetn(aresetn),
        .go(go), .request(req), .accept(acc), .accept_pc(apc), .ret(ret));
    always #5 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, e, input string n);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic end_of_test;
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        do
        begin
            @(posedge aclk);
            if (awv && awr) begin ta = 1; awv <= 0; end
            if (wv && wr_rdy) begin tw = 1; wv <= 0; end
        end while (!(ta && tw));
        do @(posedge aclk); while (!bv);
        check({30'h0, bresp}, 32'h0, "bresp");
    endtask : wr
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        ara <= {24'h0, a};
        arv <= 1;
        rr <= 1;
        do @(posedge aclk); while (!arr);
        arv <= 0;
        do @(posedge aclk); while (!rv);
    endtask : rdx
    task automatic pulse_src(input logic [6:0] v);
        src <= v;
        @(posedge aclk);
        src <= 0;
        repeat (3) @(posedge aclk);
    endtask : pulse_src
    // Read results are matched against the oldest note
    always @(posedge aclk)
        if (rv && rr)
        begin
            check(rd, expq.pop_front(), "rdata");
            check({30'h0, rresp}, 32'h0, "rresp");
        end
    initial
    begin
        #300us;
        num_errors++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] ra[4];
        logic [15:0] rm[4], rs[4];
        logic [31:0] d;
        ra = '{ADDR_I2C2_PRIO, ADDR_RTC_PRIO, ADDR_CRC_UART_PRIO,
            ADDR_LVD_PRIO};
        rm = '{MASK_I2C2, MASK_RTC, MASK_CRC_UART, MASK_LVD};
        rs = '{16'h0440, 16'h0400, 16'h4440, 16'h0004};
        void'($urandom(78293));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++)
            rdx(ra[i], {16'h0, rs[i]});
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom();
            wr(ra[i], d);
            rdx(ra[i], {16'h0, d[15:0] & rm[i]});
        end
        wr(8'h34, 32'hFFFF);
        rdx(8'h30, 32'h0);
        wr(ADDR_I2C2_PRIO, 32'h0);
        wr(ADDR_RTC_PRIO, 32'h0500);
        wr(ADDR_CRC_UART_PRIO, 32'h0030);
        wr(ADDR_LVD_PRIO, 32'h0005);
        wr(ADDR_SRC_PEND, 32'h0);
        wr(ADDR_SRC_ENABLE, 32'h7F);
        pulse_src(7'h7F);
        check({23'h0, req}, {23'h0, 1'b1, 1'b0, 4'h5, 3'h2}, "req");
        go <= 1;
        @(posedge aclk);
        go <= 0;
        for (int i = 0; i < 40 && !ret; i++) @(posedge aclk);
        @(posedge aclk);
        check({16'h0, rpc}, 32'h1234, "restore_pc");
        check({24'h0, slb}, 32'h0, "status_low_byte");
        repeat (3) @(posedge aclk);
        check({23'h0, req}, {23'h0, 1'b1, 1'b0, 4'h5, 3'h2}, "reentry");
        // nesting off, rival raised in handler
        wr(ADDR_INTR_CTRL_ONE, 32'h8000);
        go <= 1;
        @(posedge aclk);
        go <= 0;
        wr(ADDR_LVD_PRIO, 32'h0006);
        repeat (2) @(posedge aclk);
        check({31'h0, req.valid}, 32'h0, "nest");
        for (int i = 0; i < 40 && !ret; i++) @(posedge aclk);
        @(posedge aclk);
        wr(ADDR_CPU_STATUS, 32'hE0);
        repeat (3) @(posedge aclk);
        check({31'h0, req.valid}, 32'h0, "cpu7_block");
        trp <= 4'h2;
        @(posedge aclk);
        trp <= 0;
        repeat (3) @(posedge aclk);
        check({26'h0, req.valid, req.is_trap, req.level}, 32'h39,
            "trap");
        wr(ADDR_INTR_CTRL_ONE, 32'h0);
        wr(ADDR_CPU_STATUS, 32'h0);
        wr(ADDR_SRC_PEND, 32'h0);
        wr(ADDR_RTC_PRIO, 32'h0700);
        tdc <= 14'd60;
        tdi <= 1;
        @(posedge aclk);
        tdi <= 0;
        pulse_src(7'h40);
        check({31'h0, req.valid}, 32'h0, "mute_block");
        pulse_src(7'h04);
        check({23'h0, req}, {23'h0, 1'b1, 1'b0, 4'h7, 3'h2}, "mute_7");
        wr(ADDR_SRC_PEND, 32'h40);
        repeat (60) @(posedge aclk);
        check({23'h0, req}, {23'h0, 1'b1, 1'b0, 4'h6, 3'h6}, "mute_end");
        rdx(ADDR_IRQ_STATUS, 32'h7);
        wr(ADDR_IRQ_MASK, 32'h4);
        check({31'h0, irq}, 32'h1, "irq_set");
        wr(ADDR_IRQ_STATUS, 32'h7);
        rdx(ADDR_IRQ_STATUS, 32'h0);
        @(posedge aclk);
        check({31'h0, irq}, 32'h0, "irq");
        repeat (3) @(posedge aclk);
        end_of_test();
    end
endmodule : interrupt_priority_control_tb
`default_nettype wire
